/* File: src/epd_consts.svh */
// Purpose: offsets, field positions, reset values and limits of the encoder pulse divider
// Assumes: included by its bare name from the design files
// Notes:   definitions only
`ifndef EPD_CONSTS_SVH
`define EPD_CONSTS_SVH

// encoder counts per motor revolution (20-bit encoder)
`define EPD_ENC_RES        21'h10_0000
`define EPD_ENC_LAST       20'hF_FFFF
// largest numerator and denominator accepted, and smallest numerator
`define EPD_CFG_MAX        19'h4_0000
`define EPD_CFG_ONE        19'h0_0001

// register byte offsets
`define EPD_OFF_NUM        8'h00
`define EPD_OFF_DEN        8'h04
`define EPD_OFF_CTRL       8'h08
`define EPD_OFF_STATUS     8'h0C
`define EPD_OFF_MASK       8'h10
`define EPD_OFF_POS        8'h14
`define EPD_OFF_REVS       8'h18

// control fields
`define EPD_CTRL_DIR_LSB   0
`define EPD_CTRL_DIR_MSB   1
`define EPD_CTRL_REGEN_BIT 2
`define EPD_CTRL_OUTEN_BIT 3

// status and mask fields
`define EPD_ST_INDEX_BIT   0
`define EPD_ST_REGEN_BIT   1

// reset values
`define EPD_NUM_RST        19'h0_09C4
`define EPD_DEN_RST        19'h0_0000
`define EPD_CTRL_RST       4'h8
`define EPD_MASK_RST       2'h0

// bus answers
`define EPD_RESP_OKAY      2'h0
`define EPD_RESP_SLVERR    2'h2

`endif

/* File: src/epd_pkg.sv */
// Purpose: types shared by the encoder pulse divider
// Assumes: nothing
// Notes:   one-hot channel states
package epd_pkg;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b01,
        WS_RESP = 2'b10
    } epd_wr_state_e;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b01,
        RS_DATA = 2'b10
    } epd_rd_state_e;

endpackage

/* File: src/epd_quad_out.sv */
// Purpose: quadrature A/B and index generator for regenerated pulses
// Assumes: at most one of edge_fwd and edge_rev per cycle
// Notes:   all outputs come from flip-flops
`timescale 1ns/100ps
module epd_quad_out
    import epd_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic edge_fwd,
    input  wire logic edge_rev,
    input  wire logic enc_step,
    input  wire logic invert_b,
    input  wire logic rev_wrap,
    input  wire logic acc_zero,
    output logic      out_a,
    output logic      out_b,
    output logic      out_z
);

    logic [1:0] phase;
    logic [1:0] next_phase;
    logic       z_aligned;

    // forward walks 0-1-2-3 so a leads b; reverse walks back
    always_comb begin
        next_phase = phase;
        if (edge_fwd) begin
            next_phase = phase + 2'h1;
        end else if (edge_rev) begin
            next_phase = phase - 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'h0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            phase <= next_phase;
            out_a <= next_phase[0] ^ next_phase[1];
            out_b <= next_phase[1] ^ invert_b;
        end
    end

    // aligned index spans one output quarter at phase zero; otherwise one raw count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_z     <= 1'b0;
            z_aligned <= 1'b0;
        end else if (rev_wrap) begin
            out_z     <= 1'b1;
            z_aligned <= acc_zero && (next_phase == 2'h0);
        end else if (out_z) begin
            if (z_aligned ? (edge_fwd || edge_rev) : enc_step) begin
                out_z <= 1'b0;
            end
        end
    end

endmodule

/* File: src/epd_encoder_divider.sv */
// Purpose: encoder dividing output, regenerates A/B/Z pulses from motor encoder counts
// Assumes: enc_fwd/enc_rev are one-cycle count pulses synchronous to aclk, one count per cycle at most
// Notes:   registers over AXI4-Lite, status bits clear on read
//
// Behaviour
// - output pulses per revolution can be set from one up to a quarter of the encoder resolution.
// - the numerator sets the per-revolution count of both phase A and phase B alike.
// - with a zero denominator the output makes four times the numerator edges per revolution, numerator 1 to 262144.
// - with a nonzero denominator the output count per revolution is numerator over denominator times the resolution.
// - one index pulse is output for every motor revolution.
// - with a nonzero denominator the index lines up with phase A only when the output count is a multiple of four.
// - when not lined up, the index lasts one raw encoder count and may be narrower than an output period.
// - direction select 0 leaves phase B as is, 1 inverts it, and 2 and 3 are reserved.
// - the regeneration limit enable turns detection of the regeneration error alarm off at 0 and on at 1.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "epd_consts.svh"
module epd_encoder_divider
    import epd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        enc_fwd,
    input  wire logic        enc_rev,
    output logic             enc_out_a,
    output logic             enc_out_b,
    output logic             enc_out_z,
    output logic             regen_alarm,
    output logic             irq
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // out-of-range values are pulled to the nearest legal one
    function automatic logic [18:0] clamp_cfg(input logic [31:0] v,
                                              input logic        zero_ok);
        logic [18:0] res;
        res = v[18:0];
        if (v > {13'h0_000, `EPD_CFG_MAX}) begin
            res = `EPD_CFG_MAX;
        end else if ((v == 32'h0000_0000) && !zero_ok) begin
            res = `EPD_CFG_ONE;
        end
        return res;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        return (w == `EPD_OFF_NUM)    || (w == `EPD_OFF_DEN)  ||
               (w == `EPD_OFF_CTRL)   || (w == `EPD_OFF_MASK) ||
               (w == `EPD_OFF_STATUS) || (w == `EPD_OFF_POS)  ||
               (w == `EPD_OFF_REVS);
    endfunction

    epd_wr_state_e wr_state;
    epd_rd_state_e rd_state;

    logic [7:0]  aw_addr_q;
    logic        aw_held;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_held;
    logic        aw_take;
    logic        w_take;
    logic        ar_take;
    logic        have_aw;
    logic        have_w;
    logic        do_write;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_word;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  rd_word;
    logic [31:0] rd_value;

    logic [18:0] numerator;
    logic [18:0] denominator;
    logic [1:0]  output_direction_select;
    logic        regen_limit_enable;
    logic        out_enable;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [1:0]  status_clr;
    logic [1:0]  events;
    logic        cfg_write;

    logic [19:0] position;
    logic [31:0] revolutions;
    logic [20:0] acc;
    logic [20:0] next_acc;
    logic [20:0] inc_raw;
    logic [20:0] inc;
    logic [20:0] modulus;
    logic [21:0] sum;
    logic [21:0] sum_wrap;
    logic        over_rate;
    logic        step_f;
    logic        step_r;
    logic        edge_fwd;
    logic        edge_rev;
    logic        rev_wrap;
    logic        regen_event;
    localparam logic [3:0] ctrl_rst = `EPD_CTRL_RST;

    assign s_axi_awready = (wr_state == WS_IDLE) && !aw_held;
    assign s_axi_wready  = (wr_state == WS_IDLE) && !w_held;
    assign aw_take  = s_axi_awvalid && s_axi_awready;
    assign w_take   = s_axi_wvalid && s_axi_wready;
    assign have_aw  = aw_held || aw_take;
    assign have_w   = w_held || w_take;
    assign do_write = (wr_state == WS_IDLE) && have_aw && have_w;
    assign wr_addr  = aw_held ? aw_addr_q : s_axi_awaddr;
    assign wr_data  = w_held ? w_data_q : s_axi_wdata;
    assign wr_strb  = w_held ? w_strb_q : s_axi_wstrb;
    assign wr_word  = {wr_addr[7:2], 2'b00};

    // address and data may come in either order; each is held until its partner arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held    <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_held   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= WS_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EPD_RESP_OKAY;
        end else begin
            case (wr_state)
                WS_IDLE: begin
                    if (do_write) begin
                        wr_state     <= WS_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= addr_mapped(wr_addr) ? `EPD_RESP_OKAY : `EPD_RESP_SLVERR;
                    end
                end
                WS_RESP: begin
                    if (s_axi_bready) begin
                        wr_state     <= WS_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state     <= WS_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    assign cfg_write = do_write && ((wr_word == `EPD_OFF_NUM) || (wr_word == `EPD_OFF_DEN));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            numerator   <= `EPD_NUM_RST;
            denominator <= `EPD_DEN_RST;
        end else if (do_write) begin
            if (wr_word == `EPD_OFF_NUM) begin
                numerator <= clamp_cfg(merge_bytes({13'h0_000, numerator}, wr_data, wr_strb), 1'b0);
            end
            if (wr_word == `EPD_OFF_DEN) begin
                denominator <= clamp_cfg(merge_bytes({13'h0_000, denominator}, wr_data, wr_strb), 1'b1);
            end
        end
    end

    // reserved direction codes are stored but only bit 0 steers phase B
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_direction_select <= ctrl_rst[`EPD_CTRL_DIR_MSB:`EPD_CTRL_DIR_LSB];
            regen_limit_enable      <= ctrl_rst[`EPD_CTRL_REGEN_BIT];
            out_enable              <= ctrl_rst[`EPD_CTRL_OUTEN_BIT];
        end else if (do_write && (wr_word == `EPD_OFF_CTRL) && wr_strb[0]) begin
            output_direction_select <= wr_data[`EPD_CTRL_DIR_MSB:`EPD_CTRL_DIR_LSB];
            regen_limit_enable      <= wr_data[`EPD_CTRL_REGEN_BIT];
            out_enable              <= wr_data[`EPD_CTRL_OUTEN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask <= `EPD_MASK_RST;
        end else if (do_write && (wr_word == `EPD_OFF_MASK) && wr_strb[0]) begin
            mask <= wr_data[1:0];
        end
    end

    assign s_axi_arready = (rd_state == RS_IDLE);
    assign ar_take       = s_axi_arvalid && s_axi_arready;
    assign rd_word       = {s_axi_araddr[7:2], 2'b00};

    always_comb begin
        rd_value = 32'h0000_0000;
        case (rd_word)
            `EPD_OFF_NUM:    rd_value = {13'h0_000, numerator};
            `EPD_OFF_DEN:    rd_value = {13'h0_000, denominator};
            `EPD_OFF_CTRL:   rd_value = {28'h000_0000, out_enable, regen_limit_enable, output_direction_select};
            `EPD_OFF_STATUS: rd_value = {30'h0000_0000, status};
            `EPD_OFF_MASK:   rd_value = {30'h0000_0000, mask};
            `EPD_OFF_POS:    rd_value = {12'h000, position};
            `EPD_OFF_REVS:   rd_value = revolutions;
            default:         rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state     <= RS_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `EPD_RESP_OKAY;
        end else begin
            case (rd_state)
                RS_IDLE: begin
                    if (ar_take) begin
                        rd_state     <= RS_DATA;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata  <= rd_value;
                        s_axi_rresp  <= addr_mapped(s_axi_araddr) ? `EPD_RESP_OKAY : `EPD_RESP_SLVERR;
                    end
                end
                RS_DATA: begin
                    if (s_axi_rready) begin
                        rd_state     <= RS_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    rd_state     <= RS_IDLE;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // zero denominator: 4*num edges per resolution counts; else num edges per den counts
    assign inc_raw   = (denominator == 19'h0_0000) ? {numerator, 2'b00} : {2'b00, numerator};
    assign modulus   = (denominator == 19'h0_0000) ? `EPD_ENC_RES : {2'b00, denominator};
    // more than one edge per count cannot be regenerated; clamp and report
    assign over_rate = inc_raw > modulus;
    assign inc       = over_rate ? modulus : inc_raw;
    assign step_f    = enc_fwd && !enc_rev && out_enable;
    assign step_r    = enc_rev && !enc_fwd && out_enable;
    assign sum       = {1'b0, acc} + {1'b0, inc};
    assign sum_wrap  = sum - {1'b0, modulus};

    always_comb begin
        next_acc = acc;
        edge_fwd = 1'b0;
        edge_rev = 1'b0;
        if (step_f) begin
            if (sum >= {1'b0, modulus}) begin
                next_acc = sum_wrap[20:0];
                edge_fwd = 1'b1;
            end else begin
                next_acc = sum[20:0];
            end
        end else if (step_r) begin
            if (acc >= inc) begin
                next_acc = acc - inc;
            end else begin
                next_acc = acc + modulus - inc;
                edge_rev = 1'b1;
            end
        end
    end

    // new ratio restarts the fraction so no stale remainder exceeds the new modulus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= 21'h00_0000;
        end else if (cfg_write) begin
            acc <= 21'h00_0000;
        end else begin
            acc <= next_acc;
        end
    end

    assign rev_wrap = (step_f && (position == `EPD_ENC_LAST)) ||
                      (step_r && (position == 20'h0_0000));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position    <= 20'h0_0000;
            revolutions <= 32'h0000_0000;
        end else if (step_f) begin
            position <= position + 20'h0_0001;
            if (position == `EPD_ENC_LAST) begin
                revolutions <= revolutions + 32'h0000_0001;
            end
        end else if (step_r) begin
            position <= position - 20'h0_0001;
            if (position == 20'h0_0000) begin
                revolutions <= revolutions - 32'h0000_0001;
            end
        end
    end

    assign regen_event = regen_limit_enable && over_rate && (step_f || step_r);
    assign events      = {regen_event, rev_wrap};
    assign status_clr  = (ar_take && (rd_word == `EPD_OFF_STATUS)) ? 2'h3 : 2'h0;

    // a new event in the clearing cycle survives the read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= 2'h0;
        end else begin
            status <= (status & ~status_clr) | events;
        end
    end

    // alarm holds until reset, like a drive fault
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regen_alarm <= 1'b0;
        end else if (regen_event) begin
            regen_alarm <= 1'b1;
        end
    end

    assign irq = |(status & mask);

    epd_quad_out u_quad_out (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .edge_fwd (edge_fwd),
        .edge_rev (edge_rev),
        .enc_step (step_f || step_r),
        .invert_b (output_direction_select[0]),
        .rev_wrap (rev_wrap),
        .acc_zero (next_acc == 21'h00_0000),
        .out_a    (enc_out_a),
        .out_b    (enc_out_b),
        .out_z    (enc_out_z)
    );

endmodule

/* File: bench/epd_div_chk.sv */
// Purpose: port-level checks of the encoder pulse divider
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   bound into the top module after endmodule
`timescale 1ns/100ps
module epd_div_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        enc_fwd,
    input wire logic        enc_rev,
    input wire logic        enc_out_a,
    input wire logic        enc_out_b,
    input wire logic        enc_out_z,
    input wire logic        regen_alarm
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both inputs high is no count either
    sequence s_idle;
        !(enc_fwd ^ enc_rev);
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_quad_step: assert property (!($changed(enc_out_a) && $changed(enc_out_b)))
        else $error("both phases moved at once");
    a_a_idle_hold: assert property (s_idle |=> $stable(enc_out_a))
        else $error("phase A moved without a count");
    a_z_idle_hold: assert property (s_idle |=> !$rose(enc_out_z))
        else $error("index rose without a count");
    a_alarm_latch: assert property (regen_alarm |=> regen_alarm)
        else $error("regeneration alarm released");
    a_alarm_cause: assert property (s_idle |=> !$rose(regen_alarm))
        else $error("alarm rose without a count");
    a_resp_cause: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid))
        else $error("write response without request");
endmodule

bind epd_encoder_divider epd_div_chk u_epd_div_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .enc_fwd, .enc_rev, .enc_out_a, .enc_out_b, .enc_out_z, .regen_alarm
);

/* File: bench/epd_pulse_counter.sv */
// Purpose: host controller model counting regenerated quadrature pulses
// Assumes: A leads B when counting up
// Notes:   a two-step jump is illegal quadrature and is counted as bad
`timescale 1ns/100ps
module epd_pulse_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic qa,
    input wire logic qb,
    input wire logic qz,
    output int       pos,
    output int       z_cnt,
    output int       bad
);
    logic [1:0] last;
    logic       last_z;
    function automatic logic [1:0] ph(input logic a, input logic b);
        return {b, a ^ b};
    endfunction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {pos, z_cnt, bad} <= '0;
            {last, last_z} <= '0;
        end else begin
            last <= ph(qa, qb);
            last_z <= qz;
            if (qz && !last_z) z_cnt <= z_cnt + 1;
            case (ph(qa, qb) - last)
                2'd1: pos <= pos + 1;
                2'd3: pos <= pos - 1;
                2'd2: bad <= bad + 1;
                default: ;
            endcase
        end
    end
endmodule

/* File: bench/test_epd_encoder_divider.sv */
// Purpose: self-checking bench of the encoder pulse divider
// Assumes: partner model counts the regenerated pulses
// Notes:   a full turn is too long, so wraps are made around position 0
`timescale 1ns/100ps
`include "epd_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_epd_encoder_divider;
    localparam logic [1:0] ok = `EPD_RESP_OKAY;
    localparam logic [1:0] er = `EPD_RESP_SLVERR;
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        enc_fwd, enc_rev, enc_out_a, enc_out_b, enc_out_z, regen_alarm, irq;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          pc_pos, pc_z, pc_bad, p0;

    epd_encoder_divider u_epd_encoder_divider (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .enc_fwd, .enc_rev, .enc_out_a, .enc_out_b, .enc_out_z, .regen_alarm, .irq
    );
    epd_pulse_counter u_epd_pulse_counter (
        .aclk, .aresetn, .qa(enc_out_a), .qb(enc_out_b), .qz(enc_out_z),
        .pos(pc_pos), .z_cnt(pc_z), .bad(pc_bad)
    );

    always #10 aclk = ~aclk;

    task automatic complete_run;
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
    endtask

    // counts back to back, then time for the partner to settle
    task automatic cnt(input logic fwd, input int n);
        repeat (n) begin
            @(posedge aclk);
            {enc_fwd, enc_rev} <= {fwd, !fwd};
        end
        @(posedge aclk);
        {enc_fwd, enc_rev} <= 2'b00;
        repeat (3) @(posedge aclk);
    endtask

    task automatic t_reset;
        `CHK({enc_out_a, enc_out_b, enc_out_z, regen_alarm, irq}, 5'h00)
        rd(`EPD_OFF_NUM, 32'h0000_09C4, ok);
        rd(`EPD_OFF_DEN, 32'h0000_0000, ok);
        rd(`EPD_OFF_CTRL, 32'h0000_0008, ok);
        rd(`EPD_OFF_MASK, 32'h0000_0000, ok);
        rd(8'h1C, 32'h0000_0000, er);
        wr(8'h1C, 32'hFFFF_FFFF, er);
    endtask

    // reverse wrap leaves phase 3: unaligned index
    task automatic t_index;
        wr(`EPD_OFF_MASK, 32'h0000_0001, ok);
        wr(`EPD_OFF_NUM, 32'h0000_0004, ok);
        wr(`EPD_OFF_DEN, 32'h0000_0004, ok);
        p0 = pc_z;
        cnt(1'b0, 1);
        `CHK({enc_out_z, enc_out_a, enc_out_b, irq}, 4'b1011)
        rd(`EPD_OFF_POS, 32'h000F_FFFF, ok);
        rd(`EPD_OFF_STATUS, 32'h0000_0001, ok);
        `CHK(irq, 1'b0)
        cnt(1'b0, 1);
        `CHK(enc_out_z, 1'b0)
        cnt(1'b1, 2);
        `CHK({enc_out_z, enc_out_a, enc_out_b}, 3'b100)
        rd(`EPD_OFF_REVS, 32'h0000_0000, ok);
        cnt(1'b1, 1);
        `CHK(enc_out_z, 1'b0)
        wr(`EPD_OFF_MASK, 32'h0000_0000, ok);
        `CHK(irq, 1'b0)
        rd(`EPD_OFF_STATUS, 32'h0000_0001, ok);
        `CHK(pc_z - p0, 2)
    endtask

    task automatic t_rate;
        wr(`EPD_OFF_DEN, 32'h0000_0000, ok);
        wr(`EPD_OFF_NUM, 32'h0007_FFFF, ok);
        rd(`EPD_OFF_NUM, 32'h0004_0000, ok);
        p0 = pc_pos;
        cnt(1'b1, 8);
        `CHK(pc_pos - p0, 8)
        wr(`EPD_OFF_NUM, 32'h0000_0000, ok);
        rd(`EPD_OFF_NUM, 32'h0000_0001, ok);
        p0 = pc_pos;
        cnt(1'b1, 8);
        `CHK(pc_pos - p0, 0)
    endtask

    task automatic t_ratio;
        wr(`EPD_OFF_NUM, 32'h0000_0001, ok);
        wr(`EPD_OFF_DEN, 32'h0000_0004, ok);
        p0 = pc_pos;
        cnt(1'b1, 16);
        `CHK(pc_pos - p0, 4)
        p0 = pc_pos;
        cnt(1'b0, 16);
        `CHK(pc_pos - p0, -4)
        wr(`EPD_OFF_DEN, 32'h0007_FFFF, ok);
        rd(`EPD_OFF_DEN, 32'h0004_0000, ok);
    endtask

    task automatic t_dir;
        wr(`EPD_OFF_CTRL, 32'h0000_0009, ok);
        wr(`EPD_OFF_NUM, 32'h0000_0004, ok);
        wr(`EPD_OFF_DEN, 32'h0000_0004, ok);
        p0 = pc_pos;
        cnt(1'b1, 8);
        `CHK(pc_pos - p0, -8)
        wr(`EPD_OFF_CTRL, 32'h0000_000A, ok);
        rd(`EPD_OFF_CTRL, 32'h0000_000A, ok);
        p0 = pc_pos;
        cnt(1'b1, 8);
        `CHK(pc_pos - p0, 8)
    endtask

    // numerator above denominator asks for more than one edge per count
    task automatic t_regen;
        wr(`EPD_OFF_CTRL, 32'h0000_0008, ok);
        wr(`EPD_OFF_NUM, 32'h0000_0008, ok);
        p0 = pc_pos;
        cnt(1'b1, 4);
        `CHK(pc_pos - p0, 4)
        `CHK(regen_alarm, 1'b0)
        wr(`EPD_OFF_MASK, 32'h0000_0002, ok);
        wr(`EPD_OFF_CTRL, 32'h0000_000C, ok);
        cnt(1'b1, 1);
        `CHK({regen_alarm, irq}, 2'b11)
        rd(`EPD_OFF_STATUS, 32'h0000_0002, ok);
        `CHK({regen_alarm, irq}, 2'b10)
    endtask

    initial begin
        aclk = 1'b0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {enc_fwd, enc_rev, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_index;
        t_rate;
        t_ratio;
        t_dir;
        t_regen;
        `CHK(pc_bad, 0)
        complete_run;
    end

    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        complete_run;
    end
endmodule
